// [src/dtsb_pkg.sv]
package dtsb_pkg;

    // Trace status codes driven on the three trace status pins.
    typedef enum logic [2:0] {
        code_debug_run      = 3'h0,
        code_trace_trigger  = 3'h1,
        code_trace_at_stall = 3'h2,
        code_sequential     = 3'h3,
        code_exception      = 3'h4,
        code_jump_no_pc     = 3'h5,
        code_jump_with_pc   = 3'h6,
        code_stall          = 3'h7
    } dtsb_code_t;

    // Pipeline events reported by the core each cycle.
    typedef struct packed {
        logic debug_run;
        logic exception;
        logic jump_with_pc;
        logic jump_no_pc;
        logic trace_trigger;
        logic trace_at_stall;
        logic stall;
    } dtsb_pipe_t;

    // One bus transaction start: source, kind and block address.
    typedef struct packed {
        logic        from_cpu;
        logic        is_instr;
        logic [27:0] blk_addr;
    } dtsb_txn_t;

    // One data acknowledge: source and kind.
    typedef struct packed {
        logic from_cpu;
        logic is_instr;
    } dtsb_ack_t;

    // Boot sequencing states.
    typedef enum logic [2:0] {
        ST_COLD  = 3'h1,
        ST_LATCH = 3'h2,
        ST_RUN   = 3'h4
    } dtsb_state_t;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_TCK_CNT  = 8'h08;

    // Control register fields and reset value.
    localparam int         CTRL_TRACE_EN_BIT = 0;
    localparam logic [0:0] CTRL_RESET        = 1'h1;

    // Status register field positions.
    localparam int STS_MODE_LSB  = 0;
    localparam int STS_SAT_BIT   = 8;
    localparam int STS_TMS_BIT   = 9;
    localparam int STS_RUN_BIT   = 10;
    localparam int STS_COUNT_LSB = 12;

    // Boot mode bit positions of the shared debug pins.
    localparam int MODE_IDN_BIT = 3;
    localparam int MODE_ACK_BIT = 4;
    localparam int MODE_ADS_BIT = 5;
    localparam int MODE_SRC_BIT = 6;

    // Boot source code in mode bits [2:0] that means PCI boot.
    localparam logic [2:0] BOOT_PCI_CODE = 3'h7;

    // Buffer depth and the entry count that means full.
    localparam int         BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL  = 2'h2;

endpackage

// [src/dtsb_top.sv]
`timescale 1ns/10ps
module dtsb_top (
    input  wire logic              CLK,
    input  wire logic              RESET,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire dtsb_pkg::dtsb_pipe_t PIPE,
    input  wire logic              TXN_VALID,
    input  wire dtsb_pkg::dtsb_txn_t  TXN,
    output logic                   TXN_READY,
    input  wire logic              ACK_VALID,
    input  wire dtsb_pkg::dtsb_ack_t  ACK,
    input  wire logic              COLDRESET_N,
    input  wire logic              ADDR20_IN,
    input  wire logic [2:0]        PCST_IN,
    output logic      [2:0]        PCST_OUT,
    output logic                   PCST_OE_N,
    input  wire logic [3:0]        DBG_IN,
    output logic      [3:0]        DBG_OUT,
    output logic                   DBG_OE_N,
    output logic      [27:0]       MEM_BLK_ADDR,
    input  wire logic              TCK,
    input  wire logic              TMS,
    output logic                   TMS_SAMPLE,
    output logic                   TMS_STROBE,
    output logic                   PCI_SATELLITE,
    output logic                   EEPROM_LOAD
);
    import dtsb_pkg::*;

    // Synchronisers for every pin that arrives from outside the clock domain.
    logic [8:0]  pin_s1;
    logic [8:0]  pin_s2;
    logic [1:0]  tck_s1;
    logic [1:0]  tck_s2;
    logic        tck_prev;
    logic        cold_active;
    logic        tck_rise;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            pin_s1 <= 9'h1FF;
            pin_s2 <= 9'h1FF;
        end
        else
        begin
            pin_s1 <= {COLDRESET_N, ADDR20_IN, DBG_IN, PCST_IN};
            pin_s2 <= pin_s1;
        end
    end

    // The test clock is sampled like data; its edges are found after two flops.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tck_s1   <= 2'h0;
            tck_s2   <= 2'h0;
            tck_prev <= 1'h0;
        end
        else
        begin
            tck_s1   <= {TMS, TCK};
            tck_s2   <= tck_s1;
            tck_prev <= tck_s2[0];
        end
    end

    assign cold_active = ~pin_s2[8];
    assign tck_rise    = tck_s2[0] & ~tck_prev;

    // Both inputs pass the same delay, so the select stays aligned to its edge.
    logic [15:0] tck_count;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            TMS_SAMPLE <= 1'h1;
            TMS_STROBE <= 1'h0;
            tck_count  <= 16'h0000;
        end
        else
        begin
            TMS_STROBE <= tck_rise;
            if (tck_rise)
            begin
                TMS_SAMPLE <= tck_s2[1];
                tck_count  <= tck_count + 16'h0001;
            end
        end
    end

    // Boot sequencing: capture while cold reset is low, then start driving.
    dtsb_state_t state;
    logic [6:0]  mode_bits;
    logic        satellite;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            state <= ST_COLD;
        end
        else
        begin
            unique case (state)
                ST_COLD:  state <= cold_active ? ST_COLD : ST_LATCH;
                ST_LATCH: state <= cold_active ? ST_COLD : ST_RUN;
                ST_RUN:   state <= cold_active ? ST_COLD : ST_RUN;
                default:  state <= ST_COLD;
            endcase
        end
    end

    // The last value seen before release stands, so a late-settling strap still counts.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            mode_bits <= 7'h00;
            satellite <= 1'h0;
        end
        else if (state == ST_COLD && cold_active)
        begin
            mode_bits <= {pin_s2[6:3], pin_s2[2:0]};
            satellite <= pin_s2[7];
        end
    end

    // Role output and a one-cycle EEPROM load request when a satellite latches the PCI boot code.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PCI_SATELLITE <= 1'h0;
            EEPROM_LOAD   <= 1'h0;
        end
        else
        begin
            PCI_SATELLITE <= satellite;
            EEPROM_LOAD   <= (state == ST_LATCH) && satellite
                             && (mode_bits[2:0] == BOOT_PCI_CODE);
        end
    end

    // Register bus: the answer is prepared in the setup cycle.
    logic [0:0]  ctrl;
    logic        trace_en;
    logic        bus_setup;
    logic        bus_write;
    logic [1:0]  buf_count;
    logic [31:0] status_word;

    assign trace_en    = ctrl[CTRL_TRACE_EN_BIT];
    assign bus_setup   = PSEL & ~PENABLE;
    assign bus_write   = PSEL & PENABLE & PREADY & PWRITE;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[STS_MODE_LSB +: 7]  = mode_bits;
        status_word[STS_SAT_BIT]        = satellite;
        status_word[STS_TMS_BIT]        = TMS_SAMPLE;
        status_word[STS_RUN_BIT]        = (state == ST_RUN);
        status_word[STS_COUNT_LSB +: 2] = buf_count;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PREADY  <= 1'h0;
            PSLVERR <= 1'h0;
            PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            PREADY  <= bus_setup;
            PSLVERR <= 1'h0;
            PRDATA  <= 32'h0000_0000;
            if (bus_setup)
            begin
                unique case (PADDR)
                    OFS_CTRL:    PRDATA <= {31'h0000_0000, ctrl};
                    OFS_STATUS:  PRDATA <= status_word;
                    OFS_TCK_CNT: PRDATA <= {16'h0000, tck_count};
                    default:     PSLVERR <= 1'h1;
                endcase
            end
        end
    end

    // Only the control word is writable; status is read-only.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (bus_write && PADDR == OFS_CTRL)
        begin
            ctrl <= PWDATA[0:0];
        end
    end

    // Two-entry buffer for transaction starts; it drains only while pins drive.
    dtsb_txn_t   buf_mem [BUF_DEPTH];
    logic        wr_ptr;
    logic        rd_ptr;
    logic        in_fire;
    logic        out_fire;
    logic [1:0]  next_count;
    logic        driving;

    assign driving    = (state == ST_RUN) && !cold_active;
    assign in_fire    = TXN_VALID & TXN_READY;
    assign out_fire   = (buf_count != 2'h0) & driving & trace_en;
    assign next_count = buf_count + {1'h0, in_fire} - {1'h0, out_fire};

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            buf_count <= 2'h0;
            wr_ptr    <= 1'h0;
            rd_ptr    <= 1'h0;
            TXN_READY <= 1'h0;
        end
        else
        begin
            buf_count <= next_count;
            TXN_READY <= (next_count != BUF_FULL);
            if (in_fire)
            begin
                wr_ptr <= ~wr_ptr;
            end
            if (out_fire)
            begin
                rd_ptr <= ~rd_ptr;
            end
        end
    end

    // Storage has no reset; a word is only read after it was written.
    always_ff @(posedge CLK)
    begin
        if (in_fire)
        begin
            buf_mem[wr_ptr] <= TXN;
        end
    end

    // Trace status encoding, highest priority first.
    dtsb_code_t next_code;

    always_comb
    begin
        if (PIPE.debug_run)           next_code = code_debug_run;
        else if (PIPE.exception)      next_code = code_exception;
        else if (PIPE.jump_with_pc)   next_code = code_jump_with_pc;
        else if (PIPE.jump_no_pc)     next_code = code_jump_no_pc;
        else if (PIPE.trace_trigger)  next_code = code_trace_trigger;
        else if (PIPE.trace_at_stall) next_code = code_trace_at_stall;
        else if (PIPE.stall)          next_code = code_stall;
        else                          next_code = code_sequential;
    end

    // Pin drive: enables stay off until boot bits are safely held.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PCST_OE_N <= 1'h1;
            DBG_OE_N  <= 1'h1;
        end
        else
        begin
            PCST_OE_N <= ~(driving & trace_en);
            DBG_OE_N  <= ~(driving & trace_en);
        end
    end

    // Strobes are one cycle long; a start outranks an acknowledge for the flags.
    dtsb_txn_t head;
    logic      ack_fire;

    assign head     = buf_mem[rd_ptr];
    assign ack_fire = ACK_VALID & driving & trace_en;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PCST_OUT     <= code_sequential;
            DBG_OUT      <= 4'hF;
            MEM_BLK_ADDR <= 28'h000_0000;
        end
        else
        begin
            PCST_OUT <= next_code;
            DBG_OUT  <= 4'hF;
            DBG_OUT[MODE_ADS_BIT - 3] <= ~out_fire;
            DBG_OUT[MODE_ACK_BIT - 3] <= ~ack_fire;
            if (out_fire)
            begin
                MEM_BLK_ADDR <= head.blk_addr;
                DBG_OUT[MODE_SRC_BIT - 3] <= head.from_cpu;
                DBG_OUT[MODE_IDN_BIT - 3] <= head.is_instr;
            end
            else if (ack_fire)
            begin
                DBG_OUT[MODE_SRC_BIT - 3] <= ACK.from_cpu;
                DBG_OUT[MODE_IDN_BIT - 3] <= ACK.is_instr;
            end
        end
    end

endmodule

// [dv/dtsb_chk.sv]
`timescale 1ns/10ps
module dtsb_chk
    import dtsb_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RESET,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PREADY,
    input wire dtsb_pkg::dtsb_pipe_t PIPE,
    input wire logic              ACK_VALID,
    input wire dtsb_pkg::dtsb_ack_t  ACK,
    input wire logic              COLDRESET_N,
    input wire logic [2:0]        PCST_OUT,
    input wire logic              PCST_OE_N,
    input wire logic [3:0]        DBG_OUT,
    input wire logic              DBG_OE_N,
    input wire logic [27:0]       MEM_BLK_ADDR,
    input wire logic              TCK,
    input wire logic              TMS_SAMPLE,
    input wire logic              TMS_STROBE,
    input wire logic              PCI_SATELLITE,
    input wire logic              EEPROM_LOAD
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    // The setup cycle and a shown acknowledge are the causes that the properties start from.
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_ack_shown;
        !DBG_OE_N && !DBG_OUT[1] && DBG_OUT[2];
    endsequence

    // Floated pins may hold any code, so the trace codes are only judged while driven.
    a_apb_ready_next: assert property (s_setup |=> PREADY ##1 !PREADY) else $error("Late or long PREADY.");
    a_stall_code: assert property (PIPE == 7'h01 |=> PCST_OE_N || PCST_OUT == code_stall)
        else $error("Stall code wrong.");
    a_seq_code: assert property (PIPE == 7'h00 |=> PCST_OE_N || PCST_OUT == code_sequential)
        else $error("Sequential code wrong.");
    a_tms_strobe: assert property ($rose(TCK) |-> ##[1:5] TMS_STROBE) else $error("TCK rise missed.");
    a_tms_hold: assert property ($changed(TMS_SAMPLE) |-> TMS_STROBE) else $error("TMS moved alone.");
    a_ack_strobe: assert property (ACK_VALID && !DBG_OE_N ##1 !DBG_OE_N |-> !DBG_OUT[1])
        else $error("Acknowledge strobe missing.");
    a_ack_flags: assert property (ACK_VALID ##1 s_ack_shown |->
        DBG_OUT[3] == $past(ACK.from_cpu) && DBG_OUT[0] == $past(ACK.is_instr)) else $error("Ack flags wrong.");
    a_addr_hold: assert property (!DBG_OE_N && !DBG_OUT[2] |=> !DBG_OUT[2] || $stable(MEM_BLK_ADDR))
        else $error("Block address moved.");
    a_cold_float: assert property (!COLDRESET_N [*5] |-> PCST_OE_N && DBG_OE_N)
        else $error("Pins driven in cold reset.");
    a_eeprom_sat: assert property (EEPROM_LOAD |-> PCI_SATELLITE ##1 !EEPROM_LOAD)
        else $error("EEPROM load in host role.");
endmodule

bind dtsb_top dtsb_chk u_chk (.*);

// [dv/dtsb_probe.sv]
`timescale 1ns/10ps
module dtsb_probe (
    input  wire logic [2:0] PCST_OUT,
    input  wire logic       PCST_OE_N,
    input  wire logic [3:0] DBG_OUT,
    input  wire logic       DBG_OE_N,
    input  wire logic       tck_en,
    input  wire logic [6:0] strap_mode,
    input  wire logic       strap_a20,
    output logic      [2:0] PCST_IN,
    output logic      [3:0] DBG_IN,
    output logic            ADDR20_IN,
    output logic            TCK,
    output logic            TMS,
    output logic            tms_rise
);
    logic [7:0] lfsr = 8'h5a;
    logic       tck_q = 1'b0;
    logic       tms_q = 1'b1;
    logic       rise_q = 1'b1;

    // Each pin has a single driver; the processes below work on local copies.
    assign TCK = tck_q;
    assign TMS = tms_q;
    assign tms_rise = rise_q;

    // A shared pin shows the strap while the device floats it, else the device's own level.
    assign PCST_IN = PCST_OE_N ? strap_mode[2:0] : PCST_OUT;
    assign DBG_IN = DBG_OE_N ? strap_mode[6:3] : DBG_OUT;
    assign ADDR20_IN = strap_a20;

    // The test clock parks low between bursts, as a probe leaves it.
    always
    begin
        #80;
        if (tck_en || tck_q)
            tck_q = ~tck_q;
    end

    // TMS moves only on the falling edge, so it is steady around each rise.
    always @(negedge tck_q)
    begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5]};
        tms_q <= lfsr[0];
    end
    always @(posedge tck_q)
        rise_q <= tms_q;
endmodule

// [dv/dtsb_top_tb.sv]
`timescale 1ns/10ps
module dtsb_top_tb;
    import dtsb_pkg::*;
    logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic TXN_VALID = 1'b0, ACK_VALID = 1'b0, COLDRESET_N = 1'b0, tck_en = 1'b0, strap_a20 = 1'b1;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000, seed = 32'h0000_0009, r, rd;
    logic [6:0]  strap_mode = 7'h47;
    dtsb_pipe_t  PIPE = '0;
    dtsb_txn_t   TXN = '0;
    dtsb_ack_t   ACK = '0;
    logic PREADY, PSLVERR, TXN_READY, PCST_OE_N, DBG_OE_N, TCK, TMS, TMS_SAMPLE, TMS_STROBE;
    logic PCI_SATELLITE, EEPROM_LOAD, ADDR20_IN, tms_rise, err;
    logic [2:0]  PCST_IN, PCST_OUT;
    logic [3:0]  DBG_IN, DBG_OUT;
    logic [27:0] MEM_BLK_ADDR;
    logic [31:0] PRDATA;
    dtsb_txn_t   q[$];
    int          error_cnt = 0, num_checks = 0, takes = 0, i, tck_rises = 0;

    dtsb_top u_dut (.*);
    dtsb_probe u_probe (.*);
    always #5 CLK = ~CLK;

    // Test clock rises counted at the pin; the block sees each one a few cycles later.
    always @(posedge TCK)
        if (!RESET) tck_rises++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // The highest pipeline event wins when several arrive together.
    function automatic dtsb_code_t exp_code(dtsb_pipe_t p);
        if (p.debug_run) return code_debug_run;
        if (p.exception) return code_exception;
        if (p.jump_with_pc) return code_jump_with_pc;
        if (p.jump_no_pc) return code_jump_no_pc;
        if (p.trace_trigger) return code_trace_trigger;
        if (p.trace_at_stall) return code_trace_at_stall;
        if (p.stall) return code_stall;
        return code_sequential;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s: saw %h, expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d.", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; the request stands until PREADY is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        @(posedge CLK);
        while (PREADY !== 1'b1 && n < 20)
        begin
            @(posedge CLK);
            n++;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1)
        begin
            chk(0, 1, "no PREADY");
            test_done();
        end
    endtask

    // A cold reset with given straps; the pins must float until the straps are latched.
    task automatic boot(input logic a20, input logic [6:0] m);
        int n, loads;
        @(posedge CLK);
        COLDRESET_N <= 1'b0;
        strap_a20 <= a20;
        strap_mode <= m;
        repeat (8) @(posedge CLK);
        COLDRESET_N <= 1'b1;
        loads = 0;
        for (n = 0; n < 40 && PCST_OE_N !== 1'b0; n++)
        begin
            @(posedge CLK);
            loads += EEPROM_LOAD;
        end
        chk(n < 40, 1, "pins never driven");
        if (n == 40)
            test_done();
        chk(PCI_SATELLITE, a20, "pci role");
        chk(loads, a20 && m[2:0] == BOOT_PCI_CODE, "eeprom load");
        apb(1'b0, OFS_STATUS, 0);
        chk(rd[6:0], m, "boot bits");
    endtask

    // Starts are queued when taken and matched in order against the strobes.
    always @(posedge CLK)
    begin
        if (!RESET && DBG_OE_N === 1'b0 && DBG_OUT[2] === 1'b0 && q.size() > 0)
        begin
            chk(DBG_OUT[3], q[0].from_cpu, "source pin");
            chk(DBG_OUT[0], q[0].is_instr, "kind pin");
            chk(MEM_BLK_ADDR, q[0].blk_addr, "block address");
            void'(q.pop_front());
        end
        if (!RESET && TXN_VALID && TXN_READY === 1'b1)
        begin
            q.push_back(TXN);
            takes++;
        end
        if (TMS_STROBE === 1'b1)
            chk(TMS_SAMPLE, tms_rise, "tms sample");
    end

    // Boots in both roles, then registers, trace codes and a stalled then drained stream.
    initial
    begin
        repeat (8) @(posedge CLK);
        RESET <= 1'b0;
        tck_en <= 1'b1;
        boot(1'b1, 7'h47);
        boot(1'b0, 7'h07);
        boot(1'b1, 7'(rnd()));
        apb(1'b0, OFS_CTRL, 0);
        chk(rd, 1, "ctrl reset");
        apb(1'b0, 8'h0C, 0);
        chk(err, 1, "unmapped error");
        apb(1'b0, OFS_TCK_CNT, 0);
        chk(rd[15:0] == 16'(tck_rises) || rd[15:0] == 16'(tck_rises - 1), 1, "tck count");
        for (i = 0; i < 40; i++)
        begin
            @(posedge CLK);
            PIPE <= (i < 8) ? 7'(1 << i) : 7'(rnd());
            @(posedge CLK);
            @(negedge CLK);
            chk(PCST_OUT, exp_code(PIPE), "trace code");
        end
        apb(1'b1, OFS_CTRL, 0);
        takes = 0;
        for (i = 0; i < 100; i++)
        begin
            if (i == 6)
            begin
                chk(takes, BUF_DEPTH, "words held");
                apb(1'b0, OFS_STATUS, 0);
                chk(rd[13:12], BUF_FULL, "buffer count");
                apb(1'b1, OFS_CTRL, 1);
            end
            @(posedge CLK);
            r = (i < 6) ? 32'h0000_0001 | rnd() : (i < 90) ? rnd() : 32'h0000_0000;
            if (!TXN_VALID || TXN_READY)
            begin
                TXN_VALID <= r[0];
                TXN <= 30'(r >> 2);
            end
            ACK_VALID <= r[1] && i >= 6;
            ACK <= r[3:2];
        end
        chk(q.size(), 0, "words lost");
        test_done();
    end
endmodule
